// [urb_defines.vh]
// Constants for the UART receiver and break transmitter
`ifndef URB_DEFINES_VH
`define URB_DEFINES_VH
`define URB_OSR_LAST     4'hf
`define URB_SMP_A        4'h7
`define URB_SMP_B        4'h8
`define URB_SMP_C        4'h9
`define URB_BRK_LAST     4'hc
`define URB_LAST_BIT8    4'h7
`define URB_LAST_BIT9    4'h8
`define URB_FIFO_DEPTH   2
`define URB_FIFO_AW      1
`define URB_FIFO_W       12
`define URB_RX_IDLE      3'h0
`define URB_RX_START     3'h1
`define URB_RX_DATA      3'h2
`define URB_RX_PAR       3'h3
`define URB_RX_STOP      3'h4
`define URB_RX_WAIT      3'h5
`define URB_TX_IDLE      3'h0
`define URB_TX_START     3'h1
`define URB_TX_DATA      3'h2
`define URB_TX_PAR       3'h3
`define URB_TX_STOP      3'h4
`define URB_TX_BRK       3'h5
`endif

// [urb_uart.v]
// Receive FIFO and the UART receiver with break transmitter
`timescale 1ns/1ps
`include "urb_defines.vh"

module urb_fifo #(
  parameter W  = `URB_FIFO_W,
  parameter D  = `URB_FIFO_DEPTH,
  parameter AW = `URB_FIFO_AW
) (
  input  wire         clk_sys_i,
  input  wire         rst_n_i,
  input  wire         flush_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0]  mem_reg [0:D-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0]   cnt_reg;
  wire         push;
  wire         pop;

  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      if (p == D[AW-1:0] - 1'b1) begin
        ptr_inc = {AW{1'b0}};
      end else begin
        ptr_inc = p + 1'b1;
      end
    end
  endfunction

  assign in_ready_o  = (cnt_reg != D[AW:0]);
  assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_ready_i & out_valid_o;
  assign out_data_o  = mem_reg[rp_reg];

  always @(posedge clk_sys_i) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i || flush_i) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_reg <= ptr_inc(wp_reg);
      end
      if (pop) begin
        rp_reg <= ptr_inc(rp_reg);
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

module urb_uart #(
  parameter RX_FIFO_DEPTH = `URB_FIFO_DEPTH
) (
  input  wire       clk_sys_i,
  input  wire       rst_n_i,
  input  wire       sample_tick_i,
  input  wire       rx_i,
  output wire       tx_o,
  input  wire       serial_port_enable_i,
  input  wire       receiver_enable_i,
  input  wire       transmitter_enable_i,
  input  wire       send_break_ctrl_i,
  input  wire       word_length_sel_i,
  input  wire       parity_enable_i,
  input  wire       parity_type_sel_i,
  input  wire       stop_bit_count_sel_i,
  input  wire       rx_irq_enable_i,
  input  wire       status_read_i,
  input  wire       rx_data_read_i,
  input  wire       tx_data_write_i,
  input  wire [8:0] tx_data_i,
  output wire [7:0] rx_data_o,
  output wire       rx_ninth_bit_o,
  output wire       rx_data_available_flag_o,
  output wire       overrun_flag_o,
  output wire       noise_flag_o,
  output wire       framing_fault_flag_o,
  output wire       parity_fault_flag_o,
  output wire       receiver_idle_flag_o,
  output wire       tx_holding_empty_flag_o,
  output wire       transmitter_idle_flag_o,
  output wire       rx_irq_o,
  output wire       tx_irq_o
);
  reg  [2:0]  rx_state_reg;
  reg  [3:0]  rx_phase_reg;
  reg  [3:0]  rx_bit_reg;
  reg  [1:0]  rx_smp_reg;
  reg  [8:0]  rx_shift_reg;
  reg         rx_noise_reg;
  reg         rx_parity_fault_flag_reg;
  reg         overrun_reg;
  reg         arm_rx_reg;
  reg         rx_irq_reg;
  reg  [2:0]  tx_state_reg;
  reg  [3:0]  tx_phase_reg;
  reg  [3:0]  tx_cnt_reg;
  reg  [8:0]  tx_shift_reg;
  reg         tx_par_reg;
  reg         tx_brk_reg;
  reg  [8:0]  tx_holding_reg;
  reg         tx_holding_empty_flag_reg;
  reg         transmitter_idle_flag_reg;
  reg         arm_tx_reg;
  reg         tx_irq_reg;
  reg         tx_line_reg;
  reg         tx_line_next;
  wire        rx_run;
  wire        tx_run;
  wire        rx_eval;
  wire        rx_bit;
  wire        rx_noisy;
  wire [3:0]  data_last;
  wire        rx_push;
  wire        rx_room;
  wire        rx_ovr_evt;
  wire        rx_seq_rd;
  wire [11:0] fifo_in;
  wire [11:0] fifo_out;
  wire        fifo_valid;
  wire        tx_wr;
  wire        tx_bit_end;

  function maj3;
    input a;
    input b;
    input c;
    begin
      maj3 = (a & b) | (a & c) | (b & c);
    end
  endfunction

  assign rx_run    = serial_port_enable_i & receiver_enable_i;
  assign tx_run    = serial_port_enable_i & transmitter_enable_i;
  assign data_last = word_length_sel_i ? `URB_LAST_BIT9 : `URB_LAST_BIT8;

  // Majority of three samples decides the bit; the two earlier ones are held
  assign rx_eval  = sample_tick_i && (rx_phase_reg == `URB_SMP_C) &&
                    (rx_state_reg != `URB_RX_IDLE) && (rx_state_reg != `URB_RX_WAIT);
  assign rx_bit   = maj3(rx_smp_reg[0], rx_smp_reg[1], rx_i);
  assign rx_noisy = !((rx_smp_reg[0] == rx_smp_reg[1]) && (rx_smp_reg[1] == rx_i));

  assign rx_push    = rx_eval && (rx_state_reg == `URB_RX_STOP);
  assign rx_ovr_evt = rx_push & ~rx_room;
  // Framing fault, parity fault and noise travel with the word
  assign fifo_in    = {~rx_bit, rx_parity_fault_flag_reg, rx_noise_reg | rx_noisy,
                       rx_shift_reg};
  assign rx_seq_rd  = rx_data_read_i & arm_rx_reg;

  urb_fifo #(
    .W  (`URB_FIFO_W),
    .D  (RX_FIFO_DEPTH),
    .AW (`URB_FIFO_AW)
  ) u_rx_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (~serial_port_enable_i),
    .in_valid_i  (rx_push),
    .in_ready_o  (rx_room),
    .in_data_i   (fifo_in),
    .out_valid_o (fifo_valid),
    .out_ready_i (rx_seq_rd),
    .out_data_o  (fifo_out)
  );

  // Receiver
  always @(posedge clk_sys_i) begin
    if (!rst_n_i || !rx_run) begin
      rx_state_reg <= `URB_RX_IDLE;
      rx_phase_reg <= 4'h0;
      rx_bit_reg   <= 4'h0;
      rx_smp_reg   <= 2'h0;
      rx_shift_reg <= 9'h000;
      rx_noise_reg <= 1'b0;
      rx_parity_fault_flag_reg  <= 1'b0;
    end else if (sample_tick_i) begin
      case (rx_state_reg)
        `URB_RX_IDLE: begin
          if (!rx_i) begin
            rx_state_reg <= `URB_RX_START;
            rx_phase_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
            rx_noise_reg <= 1'b0;
            rx_parity_fault_flag_reg  <= 1'b0;
          end
        end
        `URB_RX_WAIT: begin
          if (rx_i) begin
            rx_state_reg <= `URB_RX_IDLE;
          end
        end
        default: begin
          rx_phase_reg <= rx_phase_reg + 4'h1;
          if (rx_phase_reg == `URB_SMP_A) begin
            rx_smp_reg[0] <= rx_i;
          end
          if (rx_phase_reg == `URB_SMP_B) begin
            rx_smp_reg[1] <= rx_i;
          end
          if (rx_phase_reg == `URB_SMP_C) begin
            rx_noise_reg <= rx_noise_reg | rx_noisy;
            case (rx_state_reg)
              `URB_RX_START: begin
                // High at mid start bit is a glitch
                if (rx_bit) begin
                  rx_state_reg <= `URB_RX_IDLE;
                end else begin
                  rx_state_reg <= `URB_RX_DATA;
                  rx_bit_reg   <= 4'h0;
                end
              end
              `URB_RX_DATA: begin
                rx_shift_reg[rx_bit_reg] <= rx_bit;
                rx_bit_reg <= rx_bit_reg + 4'h1;
                if (rx_bit_reg == data_last) begin
                  rx_state_reg <= parity_enable_i ? `URB_RX_PAR : `URB_RX_STOP;
                end
              end
              `URB_RX_PAR: begin
                rx_parity_fault_flag_reg  <= ((^rx_shift_reg) ^ rx_bit) != parity_type_sel_i;
                rx_state_reg <= `URB_RX_STOP;
              end
              `URB_RX_STOP: begin
                // Only the first stop bit is checked; a break never starts a frame
                rx_state_reg <= rx_bit ? `URB_RX_IDLE : `URB_RX_WAIT;
              end
              default: begin
                rx_state_reg <= `URB_RX_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Flags cleared by status access then data read; set wins
  always @(posedge clk_sys_i) begin
    if (!rst_n_i || !serial_port_enable_i) begin
      overrun_reg <= 1'b0;
      arm_rx_reg  <= 1'b0;
      rx_irq_reg  <= 1'b0;
    end else begin
      overrun_reg <= rx_ovr_evt | (overrun_reg & ~rx_seq_rd);
      if (status_read_i) begin
        arm_rx_reg <= 1'b1;
      end else if (rx_data_read_i) begin
        arm_rx_reg <= 1'b0;
      end
      rx_irq_reg <= rx_irq_enable_i & rx_push;
    end
  end

  assign rx_data_o                = fifo_valid ? fifo_out[7:0] : 8'h00;
  assign rx_ninth_bit_o           = fifo_valid & fifo_out[8];
  assign noise_flag_o             = fifo_valid & fifo_out[9];
  assign parity_fault_flag_o      = fifo_valid & fifo_out[10];
  assign framing_fault_flag_o     = fifo_valid & fifo_out[11];
  assign rx_data_available_flag_o = fifo_valid;
  assign overrun_flag_o           = overrun_reg;
  assign receiver_idle_flag_o     = (rx_state_reg == `URB_RX_IDLE) ||
                                    (rx_state_reg == `URB_RX_WAIT);
  assign rx_irq_o                 = rx_irq_reg;

  // Transmitter; writes are refused while the holding register is full
  assign tx_wr      = tx_data_write_i & arm_tx_reg & tx_holding_empty_flag_reg;
  assign tx_bit_end = sample_tick_i && (tx_phase_reg == `URB_OSR_LAST);

  always @(posedge clk_sys_i) begin
    if (!rst_n_i || !serial_port_enable_i) begin
      tx_state_reg   <= `URB_TX_IDLE;
      tx_phase_reg   <= 4'h0;
      tx_cnt_reg     <= 4'h0;
      tx_shift_reg   <= 9'h000;
      tx_par_reg     <= 1'b0;
      tx_brk_reg     <= 1'b0;
      tx_holding_reg <= 9'h000;
      tx_holding_empty_flag_reg       <= 1'b1;
      transmitter_idle_flag_reg      <= 1'b1;
      arm_tx_reg     <= 1'b0;
      tx_irq_reg     <= 1'b0;
    end else begin
      tx_irq_reg <= 1'b0;
      if (status_read_i) begin
        arm_tx_reg <= 1'b1;
      end else if (tx_data_write_i) begin
        arm_tx_reg <= 1'b0;
      end
      if (tx_wr) begin
        tx_holding_reg <= tx_data_i;
        tx_holding_empty_flag_reg       <= 1'b0;
        transmitter_idle_flag_reg      <= 1'b0;
      end
      if (!tx_run) begin
        tx_state_reg <= `URB_TX_IDLE;
      end else if (tx_state_reg == `URB_TX_IDLE) begin
        tx_phase_reg <= 4'h0;
        if (send_break_ctrl_i) begin
          // Break leaves the holding register and its flag alone
          tx_brk_reg   <= 1'b1;
          tx_state_reg <= `URB_TX_START;
          transmitter_idle_flag_reg    <= 1'b0;
        end else if (!tx_holding_empty_flag_reg) begin
          tx_brk_reg   <= 1'b0;
          tx_shift_reg <= tx_holding_reg;
          tx_par_reg   <= (^tx_holding_reg[7:0]) ^ (word_length_sel_i & tx_holding_reg[8]) ^
                          parity_type_sel_i;
          tx_holding_empty_flag_reg     <= 1'b1;
          tx_irq_reg   <= 1'b1;
          tx_state_reg <= `URB_TX_START;
          transmitter_idle_flag_reg    <= 1'b0;
        end
      end else begin
        if (sample_tick_i) begin
          tx_phase_reg <= tx_phase_reg + 4'h1;
        end
        if (tx_bit_end) begin
          tx_cnt_reg <= tx_cnt_reg + 4'h1;
          case (tx_state_reg)
            `URB_TX_START: begin
              tx_cnt_reg   <= 4'h0;
              tx_state_reg <= tx_brk_reg ? `URB_TX_BRK : `URB_TX_DATA;
            end
            `URB_TX_DATA: begin
              tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
              if (tx_cnt_reg == data_last) begin
                tx_cnt_reg   <= 4'h0;
                tx_state_reg <= parity_enable_i ? `URB_TX_PAR : `URB_TX_STOP;
              end
            end
            `URB_TX_PAR: begin
              tx_cnt_reg   <= 4'h0;
              tx_state_reg <= `URB_TX_STOP;
            end
            `URB_TX_BRK: begin
              if (tx_cnt_reg == `URB_BRK_LAST) begin
                tx_cnt_reg <= 4'h0;
                if (!send_break_ctrl_i) begin
                  tx_state_reg <= `URB_TX_STOP;
                end
              end
            end
            `URB_TX_STOP: begin
              if (tx_cnt_reg == {3'h0, stop_bit_count_sel_i}) begin
                tx_state_reg <= `URB_TX_IDLE;
                transmitter_idle_flag_reg    <= 1'b1;
              end
            end
            default: begin
              tx_state_reg <= `URB_TX_IDLE;
            end
          endcase
        end
      end
    end
  end

  always @* begin
    case (tx_state_reg)
      `URB_TX_START: tx_line_next = 1'b0;
      `URB_TX_BRK:   tx_line_next = 1'b0;
      `URB_TX_DATA:  tx_line_next = tx_shift_reg[0];
      `URB_TX_PAR:   tx_line_next = tx_par_reg;
      default:       tx_line_next = 1'b1;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_line_reg <= 1'b1;
    end else begin
      tx_line_reg <= tx_line_next;
    end
  end

  assign tx_o                    = tx_line_reg;
  assign tx_holding_empty_flag_o = tx_holding_empty_flag_reg;
  assign transmitter_idle_flag_o = transmitter_idle_flag_reg;
  assign tx_irq_o                = tx_irq_reg;
endmodule

// [urb_remote.sv]
// Remote serial device model driving rx and watching tx
`timescale 1ns/1ps
module urb_remote (
  input  wire  clk_sys_i,
  input  wire  sample_tick_i,
  input  wire  tx_i,
  output logic rx_o
);
  initial rx_o = 1'b1;
  // Returns just after a tick, off the sampling edge
  task automatic wt;
    begin
      @(posedge clk_sys_i);
      while (!sample_tick_i) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
    end
  endtask
  // Glitch flips only the first of the three samples of bit g
  task automatic send(input logic [11:0] bits, input int n, input int g, input logic last);
    int k, j;
    begin
      for (k = 0; k < n; k++)
        for (j = 0; j < 16; j++) begin
          rx_o = bits[k] ^ (k == g && j == 8);
          wt();
        end
      rx_o = last;
    end
  endtask
  task automatic lowrun(output int n);
    begin
      n = 0;
      @(negedge tx_i);
      while (!tx_i) begin
        @(posedge clk_sys_i);
        n += sample_tick_i;
      end
    end
  endtask
endmodule

// [urb_uart_asserts.sv]
// Port checker for the UART receiver and break transmitter
`timescale 1ns/1ps
module urb_uart_asserts (
  input wire       clk_sys_i,
  input wire       rst_n_i,
  input wire       sample_tick_i,
  input wire       rx_i,
  input wire       serial_port_enable_i,
  input wire       send_break_ctrl_i,
  input wire       parity_enable_i,
  input wire       rx_irq_enable_i,
  input wire       rx_data_read_i,
  input wire       tx_data_write_i,
  input wire [7:0] rx_data_o,
  input wire       rx_data_available_flag_o,
  input wire       overrun_flag_o,
  input wire       parity_fault_flag_o,
  input wire       receiver_idle_flag_o,
  input wire       tx_holding_empty_flag_o,
  input wire       transmitter_idle_flag_o,
  input wire       rx_irq_o,
  input wire       tx_irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_word_irq: assert property (
    $rose(rx_data_available_flag_o) && rx_irq_enable_i |-> ##[0:1] rx_irq_o)
    else $error("no interrupt for new word");
  a_irq_cause: assert property (
    rx_irq_o |-> rx_data_available_flag_o && $past(rx_irq_enable_i))
    else $error("interrupt without cause");
  a_ovr_keep: assert property (
    $rose(overrun_flag_o) |-> $stable(rx_data_o) && rx_data_available_flag_o)
    else $error("overrun lost buffer");
  a_ovr_clear: assert property (
    $fell(overrun_flag_o) |-> $past(rx_data_read_i) || !$past(serial_port_enable_i))
    else $error("overrun cleared without read");
  a_avail_clear: assert property (
    $fell(rx_data_available_flag_o) |-> $past(rx_data_read_i) || !$past(serial_port_enable_i))
    else $error("data flag cleared without read");
  a_port_off: assert property (
    !serial_port_enable_i |=> !rx_data_available_flag_o && !overrun_flag_o
      && receiver_idle_flag_o && tx_holding_empty_flag_o && transmitter_idle_flag_o)
    else $error("disable left state");
  a_start_seen: assert property (
    $fell(receiver_idle_flag_o) |-> $past(sample_tick_i) && !$past(rx_i))
    else $error("frame began without low tick");
  a_empty_clear: assert property (
    $fell(tx_holding_empty_flag_o) |-> $past(tx_data_write_i))
    else $error("empty flag cleared without write");
  a_idle_clear: assert property (
    $fell(transmitter_idle_flag_o) |-> $past(tx_data_write_i) || $past(send_break_ctrl_i))
    else $error("tx idle cleared without cause");
  a_brk_no_irq: assert property (
    tx_irq_o |-> !$past(send_break_ctrl_i))
    else $error("tx interrupt during break");
  a_par_gate: assert property (
    parity_fault_flag_o |-> parity_enable_i)
    else $error("parity fault with parity off");
  c_overrun: cover property ($rose(overrun_flag_o));
  c_tx_load: cover property (tx_irq_o);
  c_rx_word: cover property (rx_irq_o);
endmodule
bind urb_uart urb_uart_asserts urb_uart_asserts_i (.*);

// [test_uart_receiver_and_break_tx.sv]
// Self-checking bench for the UART receiver and break transmitter
`timescale 1ns/1ps
module test_uart_receiver_and_break_tx;
  logic       clk_sys_i = 0, rst_n_i = 0, sample_tick_i = 0;
  logic       serial_port_enable_i = 1, receiver_enable_i = 1, transmitter_enable_i = 1;
  logic       send_break_ctrl_i = 0, word_length_sel_i = 0, parity_enable_i = 0;
  logic       parity_type_sel_i = 0, stop_bit_count_sel_i = 0, rx_irq_enable_i = 1;
  logic       status_read_i = 0, rx_data_read_i = 0, tx_data_write_i = 0;
  logic [8:0] tx_data_i = 9'h055;
  wire        rx_i, tx_o, rx_ninth_bit_o, rx_data_available_flag_o, overrun_flag_o;
  wire        noise_flag_o, framing_fault_flag_o, parity_fault_flag_o, receiver_idle_flag_o;
  wire        tx_holding_empty_flag_o, transmitter_idle_flag_o, rx_irq_o, tx_irq_o;
  wire  [7:0] rx_data_o;
  int         fail_count = 0, checks = 0, rxq = 0, txq = 0, cyc = 0, q, n, i;

  urb_uart urb_uart_i (.*);
  urb_remote urb_remote_i (.clk_sys_i(clk_sys_i), .sample_tick_i(sample_tick_i),
                           .tx_i(tx_o), .rx_o(rx_i));

  always #12.5 clk_sys_i = ~clk_sys_i;
  // Tick on every fourth clock keeps frames short
  always @(negedge clk_sys_i) begin
    sample_tick_i = (cyc % 4 == 0);
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      summarize();
    end
  end
  always @(posedge clk_sys_i) if (rst_n_i) begin
    rxq += rx_irq_o;
    txq += tx_irq_o;
  end

  // Wide enough for the longest flag and data group compared at once
  task chk(input logic [11:0] got, input logic [11:0] exp);
    begin
      checks++;
      if (got !== exp) begin
        fail_count++;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task acc(input logic st, input logic rd, input logic wr);
    begin
      @(negedge clk_sys_i);
      {status_read_i, rx_data_read_i, tx_data_write_i} = {st, rd, wr};
      @(negedge clk_sys_i);
      {status_read_i, rx_data_read_i, tx_data_write_i} = 3'h0;
    end
  endtask
  task pop;
    begin
      acc(1, 0, 0);
      acc(0, 1, 0);
    end
  endtask
  function automatic logic [11:0] fr(input logic [8:0] d, input int nb, input logic bad);
    begin
      fr = (12'hfff << (nb + 1)) | ({3'h0, d} << 1);
      if (parity_enable_i)
        fr[nb + 1] = ^d ^ parity_type_sel_i ^ bad;
    end
  endfunction
  task rxf(input logic [8:0] d, input logic bad, input int g);
    begin
      n = word_length_sel_i ? 9 : 8;
      urb_remote_i.send(fr(d, n, bad), n + 2 + parity_enable_i, g, 1'b1);
    end
  endtask

  task t_tx;
    begin
      q = txq;
      acc(0, 0, 1);
      chk({tx_holding_empty_flag_o, transmitter_idle_flag_o}, 9'h3);
      acc(1, 0, 0);
      acc(0, 0, 1);
      chk({tx_holding_empty_flag_o, transmitter_idle_flag_o}, 9'h0);
      repeat (192) urb_remote_i.wt();
      chk({tx_o, tx_holding_empty_flag_o, transmitter_idle_flag_o, 6'(txq - q)}, 9'h1c1);
      q = txq;
      send_break_ctrl_i = 1;
      fork
        urb_remote_i.lowrun(n);
        begin
          @(negedge tx_o);
          repeat (320) urb_remote_i.wt();
          send_break_ctrl_i = 0;
        end
      join
      // Two whole breaks; the first bit may start between ticks
      chk(9'(n >= 416 && n <= 433), 9'h1);
      repeat (48) urb_remote_i.wt();
      chk({tx_o, tx_holding_empty_flag_o, transmitter_idle_flag_o, 6'(txq - q)}, 9'h1c0);
      $display("t_tx done");
    end
  endtask
  task t_rx;
    begin
      acc(0, 1, 0);
      q = rxq;
      fork
        rxf(9'h0a5, 0, 99);
        begin
          repeat (40) urb_remote_i.wt();
          chk(receiver_idle_flag_o, 9'h0);
        end
      join
      chk({rx_data_available_flag_o, receiver_idle_flag_o, rx_data_o}, 10'h3a5);
      chk(9'(rxq - q), 9'h1);
      acc(0, 1, 0);
      chk(rx_data_available_flag_o, 9'h1);
      pop();
      chk(rx_data_available_flag_o, 9'h0);
      {word_length_sel_i, parity_enable_i} = 2'h3;
      for (i = 0; i < 4; i++) begin
        parity_type_sel_i = i[0];
        rxf(9'h13c, i[1], 99);
        chk(parity_fault_flag_o, 9'(i[1]));
        chk({rx_ninth_bit_o, rx_data_o}, 9'h13c);
        pop();
      end
      {word_length_sel_i, parity_enable_i, parity_type_sel_i} = 3'h0;
      q = rxq;
      rxf(9'h05a, 0, 4);
      chk({noise_flag_o, rx_data_o}, 9'h15a);
      chk(9'(rxq - q), 9'h1);
      pop();
      chk(noise_flag_o, 9'h0);
      $display("t_rx done");
    end
  endtask
  task t_ovr;
    begin
      q = rxq;
      for (i = 1; i < 4; i++)
        rxf(9'(i * 17), 0, 99);
      chk({overrun_flag_o, rx_data_o}, 9'h111);
      chk(9'(rxq - q), 9'h3);
      pop();
      chk({overrun_flag_o, rx_data_o}, 9'h022);
      serial_port_enable_i = 0;
      @(negedge clk_sys_i);
      serial_port_enable_i = 1;
      chk({rx_data_available_flag_o, receiver_idle_flag_o}, 9'h1);
      receiver_enable_i = 0;
      rxf(9'h077, 0, 99);
      chk(rx_data_available_flag_o, 9'h0);
      receiver_enable_i = 1;
      rxf(9'h077, 0, 99);
      chk(rx_data_o, 9'h077);
      pop();
      stop_bit_count_sel_i = 1;
      urb_remote_i.send(12'h000, 11, 99, 1'b0);
      repeat (160) urb_remote_i.wt();
      chk({rx_data_available_flag_o, framing_fault_flag_o, receiver_idle_flag_o}, 9'h7);
      chk(rx_data_o, 9'h0);
      urb_remote_i.send(12'hfff, 2, 99, 1'b1);
      pop();
      chk(rx_data_available_flag_o, 9'h0);
      $display("t_ovr done");
    end
  endtask

  task summarize;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  initial begin
    repeat (8) @(negedge clk_sys_i);
    rst_n_i = 1;
    @(negedge clk_sys_i);
    chk({tx_o, tx_holding_empty_flag_o, transmitter_idle_flag_o, receiver_idle_flag_o,
         rx_data_available_flag_o, overrun_flag_o}, 9'h03c);
    t_tx();
    t_rx();
    t_ovr();
    summarize();
  end
endmodule
